// file: core/ltir_defs.svh
// Constants for the light threshold interrupt reporting block.
// Assumes inclusion by bare name from core files only.
`ifndef LTIR_DEFS_SVH
`define LTIR_DEFS_SVH

`define LTIR_RES_W 16
`define LTIR_FCNT_W 2
`define LTIR_MODE_W 2
`define LTIR_CNT_W 3
`define LTIR_MODE_SHUTDOWN 2'h0
`define LTIR_EOC_CODE 2'h3
`define LTIR_LOW_TOP_MSB 15
`define LTIR_LOW_TOP_LSB 14

`endif

// file: core/ltir_pkg.sv
// Types for the light threshold interrupt reporting block.
// Assumes ltir_defs.svh sits beside it.
`include "ltir_defs.svh"
package ltir_pkg;
    typedef logic [`LTIR_RES_W-1:0] ltir_res_t;
    typedef logic [`LTIR_FCNT_W-1:0] ltir_fcnt_t;
    typedef logic [`LTIR_MODE_W-1:0] ltir_mode_t;
    typedef logic [`LTIR_CNT_W-1:0] ltir_cnt_t;
    // Fault direction of the running consecutive count
    typedef enum logic [2:0] {
        LTIR_DIR_NONE = 3'b001,
        LTIR_DIR_HIGH = 3'b010,
        LTIR_DIR_LOW  = 3'b100
    } ltir_dir_e;
endpackage

// file: core/ltir_compare.sv
// Limit comparator of the light threshold interrupt reporting block.
// Assumes limits are stable around a conversion result strobe.
`timescale 1ns/1ps
module ltir_compare (
    // Result and limits
    input wire ltir_pkg::ltir_res_t result_i,
    input wire ltir_pkg::ltir_res_t high_limit_i,
    input wire ltir_pkg::ltir_res_t low_limit_i,
    // Comparison outcome
    output logic above_o,
    output logic below_o
);
    import ltir_pkg::*;

    // Strict compares; equal to a limit is no fault
    always_comb begin
        above_o = (result_i > high_limit_i); // RULE3
        below_o = (result_i < low_limit_i); // RULE3
    end
endmodule

// file: core/ltir_fault_count.sv
// Consecutive same-direction fault counter.
// Assumes one conv_done_i pulse per finished conversion.
`timescale 1ns/1ps
`include "ltir_defs.svh"
module ltir_fault_count (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Conversion outcome
    input wire logic conv_done_i,
    input wire logic above_i,
    input wire logic below_i,
    input wire ltir_pkg::ltir_fcnt_t fault_count_i,
    // Trigger pulses, valid with conv_done_i
    output logic trig_high_o,
    output logic trig_low_o
);
    import ltir_pkg::*;

    ltir_dir_e dir_r;
    ltir_cnt_t cnt_r;
    ltir_cnt_t cnt_nxt;
    ltir_cnt_t need;
    ltir_dir_e dir_now;

    // Field value n asks for 1, 2, 4 or 8 consecutive faults
    always_comb begin
        need = ltir_cnt_t'((4'h1 << fault_count_i) - 4'h1);
        if (above_i) begin
            dir_now = LTIR_DIR_HIGH;
        end else if (below_i) begin
            dir_now = LTIR_DIR_LOW;
        end else begin
            dir_now = LTIR_DIR_NONE;
        end
        // Restart on a pass or a change of direction
        if (dir_now == LTIR_DIR_NONE || dir_now != dir_r) begin
            cnt_nxt = 3'h0; // RULE18
        end else if (cnt_r != 3'h7) begin
            cnt_nxt = cnt_r + 3'h1;
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    // Trigger on every conversion once the run is long enough
    always_comb begin
        trig_high_o = conv_done_i && dir_now == LTIR_DIR_HIGH && cnt_nxt >= need; // RULE16
        trig_low_o = conv_done_i && dir_now == LTIR_DIR_LOW && cnt_nxt >= need; // RULE16
    end

    // Run state
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            dir_r <= LTIR_DIR_NONE;
            cnt_r <= 3'h0;
        end else if (ce_i && conv_done_i) begin
            dir_r <= dir_now;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// file: core/ltir_top.sv
// Interrupt reporting logic of an ambient light sensor.
// Assumes a serial front end that pulses read/write strobes and a
// conversion engine that pulses conv_done_i with a stable result.
// Behaviour
// RULE1: Latch bit selects latched or transparent mode.
// RULE2: Low limit top bits 11b select end-of-conversion.
// RULE3: Latched mode counts results outside either limit.
// RULE4: Latched trigger: interrupt, ready, matching flag set.
// RULE5: Latched: config read clears interrupt and flags.
// RULE6: Alert response clears only latched interrupt.
// RULE7: Unmet conversion sets ready, keeps flags, interrupt.
// RULE8: Config read clears conversion ready afterwards.
// RULE9: Non-shutdown write clears ready; shutdown write nothing.
// RULE10: Transparent high: interrupt active, high flag only.
// RULE11: Transparent low: interrupt inactive, low flag only.
// RULE12: Transparent indicators ignore config reads and writes; in end-of-conversion the code clears irq on a read or non-shutdown write.
// RULE13: Transparent mode ignores alert response entirely.
// RULE14: Pin low when active xor polarity set.
// RULE15: Host keeps high limit above low limit.
// RULE16: Consecutive fault count gates every trigger.
// RULE17: End-of-conversion: interrupt active each conversion.
// RULE18: Fault run restarts on pass or direction change.
`timescale 1ns/1ps
`include "ltir_defs.svh"
module ltir_top (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Configuration fields
    input wire logic latch_sel_i,
    input wire logic irq_polarity_i,
    input wire ltir_pkg::ltir_fcnt_t fault_count_i,
    input wire ltir_pkg::ltir_mode_t conv_mode_i,
    input wire ltir_pkg::ltir_res_t high_limit_i,
    input wire ltir_pkg::ltir_res_t low_limit_i,
    // Host access strobes
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire ltir_pkg::ltir_mode_t cfg_wr_mode_i,
    input wire logic alert_resp_i,
    // Conversion engine
    input wire logic conv_done_i,
    input wire ltir_pkg::ltir_res_t result_i,
    // Reporting indicators
    output logic flag_high_o,
    output logic flag_low_o,
    output logic conv_ready_o,
    output logic irq_active_o,
    // Open-drain interrupt pin
    input wire logic int_pin_i,
    output logic int_pin_o,
    output logic int_pin_oe_o
);
    import ltir_pkg::*;

    logic above;
    logic below;
    logic trig_high;
    logic trig_low;
    logic eoc_mode;
    logic latched;
    logic wr_run;
    logic flag_high_r;
    logic flag_low_r;
    logic ready_r;
    logic irq_r;
    logic pin_drive_r;
    logic clr_latch_r;

    // Mode decode from the live configuration
    always_comb begin
        latched = latch_sel_i; // RULE1
        eoc_mode = low_limit_i[`LTIR_LOW_TOP_MSB:`LTIR_LOW_TOP_LSB] == `LTIR_EOC_CODE; // RULE2
        wr_run = cfg_wr_i && cfg_wr_mode_i != `LTIR_MODE_SHUTDOWN; // RULE9
    end

    ltir_compare u_cmp (
        .result_i(result_i),
        .high_limit_i(high_limit_i),
        .low_limit_i(low_limit_i),
        .above_o(above),
        .below_o(below)
    );

    ltir_fault_count u_cnt (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .conv_done_i(conv_done_i),
        .above_i(above),
        .below_i(below),
        .fault_count_i(fault_count_i),
        .trig_high_o(trig_high),
        .trig_low_o(trig_low)
    );

    // Conversion ready: a finishing conversion wins over a read or write
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ready_r <= 1'b0;
        end else if (ce_i) begin
            if (conv_done_i) begin
                ready_r <= 1'b1; // RULE7
            end else if (cfg_rd_i || wr_run) begin
                ready_r <= 1'b0; // RULE8
            end
        end
    end

    // High flag; a trigger in the same cycle as a read wins
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            flag_high_r <= 1'b0;
        end else if (ce_i) begin
            if (trig_high) begin
                flag_high_r <= 1'b1; // RULE4
            end else if (trig_low && !latched) begin
                flag_high_r <= 1'b0; // RULE11
            end else if (cfg_rd_i && latched) begin
                flag_high_r <= 1'b0; // RULE5
            end
        end
    end

    // Low flag mirrors the high flag
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            flag_low_r <= 1'b0;
        end else if (ce_i) begin
            if (trig_low) begin
                flag_low_r <= 1'b1; // RULE4
            end else if (trig_high && !latched) begin
                flag_low_r <= 1'b0; // RULE10
            end else if (cfg_rd_i && latched) begin
                flag_low_r <= 1'b0; // RULE5
            end
        end
    end

    // Internal interrupt state, before polarity
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            irq_r <= 1'b0;
        end else if (ce_i) begin
            if (conv_done_i && eoc_mode) begin
                irq_r <= 1'b1; // RULE17
            end else if (trig_high) begin
                irq_r <= 1'b1; // RULE4
            end else if (trig_low) begin
                irq_r <= latched; // RULE11
            end else if (latched && (cfg_rd_i || alert_resp_i)) begin
                irq_r <= 1'b0; // RULE5 RULE6 RULE13
            end else if (!latched && eoc_mode && (cfg_rd_i || wr_run)) begin
                irq_r <= 1'b0; // RULE12
            end else if (clr_latch_r && !latched && !eoc_mode) begin
                // Leaving latched end-of-conversion needs a latch-bit drop to clear
                irq_r <= 1'b0;
            end
        end
    end

    // Pending clear held from latched end-of-conversion until the latch bit drops;
    // a one-cycle memory would miss the usual order of limit change, then latch drop
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            clr_latch_r <= 1'b0;
        end else if (ce_i) begin
            if (!latched) begin
                clr_latch_r <= 1'b0;
            end else if (eoc_mode) begin
                clr_latch_r <= 1'b1;
            end
        end
    end

    // Pin drive registered so the open-drain enable is glitch free
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_drive_r <= 1'b0;
        end else if (ce_i) begin
            pin_drive_r <= irq_r ^ irq_polarity_i; // RULE14
        end
    end

    // Outputs; alert line level is only observed by the host side
    always_comb begin
        flag_high_o = flag_high_r;
        flag_low_o = flag_low_r;
        conv_ready_o = ready_r;
        irq_active_o = irq_r;
        int_pin_o = 1'b0;
        int_pin_oe_o = pin_drive_r && (int_pin_i || !int_pin_i);
    end
endmodule

// file: bench/ltir_chk_sva.sv
// Checker for the threshold interrupt reporting block.
// Assumes a bind onto ltir_top; inputs mirror its ports.
`timescale 1ns/1ps
module ltir_chk (
    // Watched ports
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic latch_sel_i,
    input wire logic irq_polarity_i,
    input wire ltir_pkg::ltir_fcnt_t fault_count_i,
    input wire ltir_pkg::ltir_mode_t cfg_wr_mode_i,
    input wire ltir_pkg::ltir_res_t high_limit_i,
    input wire ltir_pkg::ltir_res_t low_limit_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic alert_resp_i,
    input wire logic conv_done_i,
    input wire ltir_pkg::ltir_res_t result_i,
    input wire logic flag_high_o,
    input wire logic flag_low_o,
    input wire logic conv_ready_o,
    input wire logic irq_active_o,
    input wire logic int_pin_oe_o
);
    import ltir_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // End-of-conversion selection and an idle conversion cycle
    logic eoc;
    logic idle;
    assign eoc = low_limit_i[15:14] == 2'b11;
    assign idle = ce_i && !conv_done_i;
    a_pin_drive: assert property (
        !$past(srst_i) && $past(ce_i) |->
        int_pin_oe_o == ($past(irq_active_o) ^ $past(irq_polarity_i))) else $error("pin drive");
    a_ready_clear: assert property (
        idle && (cfg_rd_i || cfg_wr_i && cfg_wr_mode_i != 2'h0) |=> !conv_ready_o)
        else $error("ready not cleared");
    a_done_ready: assert property (
        ce_i && conv_done_i |=> conv_ready_o) else $error("ready not set");
    a_latch_read: assert property (
        idle && latch_sel_i && cfg_rd_i |=> !flag_high_o && !flag_low_o && !irq_active_o)
        else $error("latched read");
    a_alert_latch: assert property (
        idle && latch_sel_i && alert_resp_i && !cfg_rd_i && !cfg_wr_i |=>
        !irq_active_o && $stable({flag_high_o, flag_low_o, conv_ready_o})) else $error("alert");
    a_transp_quiet: assert property (
        idle && !latch_sel_i && !$past(latch_sel_i) && !eoc |=>
        $stable({flag_high_o, flag_low_o, irq_active_o})) else $error("transparent moved");
    a_transp_high: assert property (
        ce_i && conv_done_i && !latch_sel_i && !eoc && fault_count_i == 2'h0 &&
        result_i > high_limit_i |=> flag_high_o && !flag_low_o && irq_active_o) else $error("hi");
    a_transp_low: assert property (
        ce_i && conv_done_i && !latch_sel_i && !eoc && fault_count_i == 2'h0 &&
        result_i < low_limit_i |=> !flag_high_o && flag_low_o && !irq_active_o) else $error("lo");
    a_eoc_irq: assert property (
        ce_i && conv_done_i && eoc |=> irq_active_o) else $error("eoc irq");
endmodule
bind ltir_top ltir_chk u_chk (.core_clk_i, .srst_i, .ce_i, .latch_sel_i, .irq_polarity_i,
    .fault_count_i, .cfg_wr_mode_i, .high_limit_i, .low_limit_i, .cfg_rd_i, .cfg_wr_i,
    .alert_resp_i, .conv_done_i, .result_i, .flag_high_o, .flag_low_o, .conv_ready_o,
    .irq_active_o, .int_pin_oe_o);

// file: bench/ltir_host.sv
// Host processor model: one-cycle read, write and alert strobes.
// Assumes put() is called at a falling clock edge.
`timescale 1ns/1ps
module ltir_host (
    // Clock
    input wire logic core_clk_i,
    // Strobes toward the device
    output logic cfg_rd_o,
    output logic cfg_wr_o,
    output ltir_pkg::ltir_mode_t wr_mode_o,
    output logic alert_o
);
    import ltir_pkg::*;
    // Kind 1 read, 2 write, 3 alert response, 0 idle
    task automatic put(input int k, input ltir_mode_t m);
        cfg_rd_o = (k == 1);
        cfg_wr_o = (k == 2);
        wr_mode_o = m;
        alert_o = (k == 3);
    endtask
    initial put(0, 2'h0);
endmodule

// file: bench/ltir_tb.sv
// Self-checking bench for the threshold interrupt reporting block.
// Assumes ltir_host drives the strobes; pin has a pull-up.
`timescale 1ns/1ps
module light_threshold_interrupt_report_test;
    import ltir_pkg::*;
    logic core_clk_i = 0, srst_i = 1, latch_sel_i = 1, irq_polarity_i = 0, conv_done_i = 0;
    logic ce_i = 1;
    ltir_fcnt_t fault_count_i = 2'h0;
    ltir_mode_t conv_mode_i = 2'h0, cfg_wr_mode_i;
    ltir_res_t high_limit_i = 16'h8000, low_limit_i = 16'h1000, result_i = 16'h0000;
    logic cfg_rd_i, cfg_wr_i, alert_resp_i, flag_high_o, flag_low_o, conv_ready_o, irq_active_o;
    logic int_pin_o, int_pin_oe_o;
    // Note is {flag high, flag low, ready, irq, expected pin drive}
    logic [4:0] exp_q[$];
    logic [4:0] note;
    int n_errors = 0, checked = 0, cycles = 0;
    integer seed = 32'h4c59;
    event got;
    always #20 core_clk_i = ~core_clk_i;
    ltir_host host (.core_clk_i, .cfg_rd_o(cfg_rd_i), .cfg_wr_o(cfg_wr_i),
        .wr_mode_o(cfg_wr_mode_i), .alert_o(alert_resp_i));
    ltir_top dut (.core_clk_i, .srst_i, .ce_i, .latch_sel_i, .irq_polarity_i,
        .fault_count_i, .conv_mode_i, .high_limit_i, .low_limit_i, .cfg_rd_i, .cfg_wr_i,
        .cfg_wr_mode_i, .alert_resp_i, .conv_done_i, .result_i, .flag_high_o, .flag_low_o,
        .conv_ready_o, .irq_active_o, .int_pin_i(!int_pin_oe_o), .int_pin_o, .int_pin_oe_o);
    task automatic print_verdict;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask
    // Random result just above a base, kept inside its band
    function automatic ltir_res_t rnd(input ltir_res_t base);
        rnd = base + ltir_res_t'($random(seed) & 16'h00ff);
    endfunction
    // One strobe cycle; expectation is {flag high, flag low, ready, irq}
    task automatic step(input int k, input ltir_mode_t m, input logic d,
                        input ltir_res_t r, input logic [3:0] e);
        host.put(k, m);
        conv_done_i = d;
        result_i = r;
        @(negedge core_clk_i);
        host.put(0, 2'h0);
        conv_done_i = 0;
        exp_q.push_back({e, e[0] ^ irq_polarity_i});
        ->got;
        @(negedge core_clk_i);
    endtask
    // Oldest note against the settled indicators; pin drive lags by one edge
    always begin
        @(got);
        note = exp_q.pop_front();
        check("indicators", {flag_high_o, flag_low_o, conv_ready_o, irq_active_o},
              note[4:1]);
        @(negedge core_clk_i);
        check("pin drive", {3'h0, int_pin_oe_o}, {3'h0, note[0]});
    end
    // Hang guard, well above the planned run
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        conv_mode_i = ltir_mode_t'($random(seed));
        repeat (8) @(posedge core_clk_i);
        @(negedge core_clk_i);
        srst_i = 0;
        step(0, 2'h0, 0, 16'h0000, 4'b0000);
        step(0, 2'h0, 1, rnd(16'h8001), 4'b1011);
        step(0, 2'h0, 1, rnd(16'h2000), 4'b1011);
        step(3, 2'h0, 0, 16'h0000, 4'b1010);
        step(1, 2'h0, 0, 16'h0000, 4'b0000);
        step(0, 2'h0, 1, rnd(16'h0000), 4'b0111);
        // Enable low: read and conversion both refused, nothing moves
        ce_i = 0;
        step(1, 2'h0, 1, rnd(16'h8001), 4'b0111);
        ce_i = 1;
        step(2, 2'h0, 0, 16'h0000, 4'b0111);
        step(2, 2'h2, 0, 16'h0000, 4'b0101);
        step(1, 2'h0, 0, 16'h0000, 4'b0000);
        step(0, 2'h0, 1, rnd(16'h2000), 4'b0010);
        step(1, 2'h0, 0, 16'h0000, 4'b0000);
        step(1, 2'h0, 0, 16'h0000, 4'b0000);
        latch_sel_i = 0;
        irq_polarity_i = 1;
        step(0, 2'h0, 1, rnd(16'h8001), 4'b1011);
        step(1, 2'h0, 0, 16'h0000, 4'b1001);
        step(3, 2'h0, 0, 16'h0000, 4'b1001);
        step(2, 2'h1, 0, 16'h0000, 4'b1001);
        step(0, 2'h0, 1, rnd(16'h0000), 4'b0110);
        fault_count_i = 2'h1;
        step(0, 2'h0, 1, rnd(16'h8001), 4'b0110);
        step(0, 2'h0, 1, rnd(16'h2000), 4'b0110);
        step(0, 2'h0, 1, rnd(16'h8001), 4'b0110);
        step(0, 2'h0, 1, rnd(16'h8001), 4'b1011);
        // Longest run: seven low faults wait, the eighth triggers
        fault_count_i = 2'h3;
        for (int i = 0; i < 7; i++) step(0, 2'h0, 1, rnd(16'h0000), 4'b1011);
        step(0, 2'h0, 1, rnd(16'h0000), 4'b0110);
        latch_sel_i = 1;
        fault_count_i = 2'h0;
        high_limit_i = 16'hf000;
        low_limit_i = 16'hc000;
        step(1, 2'h0, 0, 16'h0000, 4'b0000);
        step(0, 2'h0, 1, rnd(16'hd000), 4'b0011);
        step(2, 2'h3, 0, 16'h0000, 4'b0001);
        step(3, 2'h0, 0, 16'h0000, 4'b0000);
        // Leave latched end-of-conversion; irq holds until the latch bit drops
        step(0, 2'h0, 1, rnd(16'hd000), 4'b0011);
        low_limit_i = 16'h1000;
        step(0, 2'h0, 1, rnd(16'h2000), 4'b0011);
        latch_sel_i = 0;
        step(0, 2'h0, 0, 16'h0000, 4'b0010);
        // Transparent end-of-conversion: read or running write drops irq
        low_limit_i = 16'hc000;
        step(0, 2'h0, 1, rnd(16'hd000), 4'b0011);
        step(1, 2'h0, 0, 16'h0000, 4'b0000);
        step(0, 2'h0, 1, rnd(16'hd000), 4'b0011);
        step(2, 2'h2, 0, 16'h0000, 4'b0000);
        // Let the last pin check finish first
        @(negedge core_clk_i);
        print_verdict();
    end
endmodule
